//--- src/epm_defines.svh
/*
 * Offsets, widths, reset values and limits of the error counter bank.
 * Assumes the channel select bits above the 12-bit offset are decoded
 * outside, and that this header is included by every file that needs it.
 */
`ifndef EPM_DEFINES_SVH
`define EPM_DEFINES_SVH

// ----------------------------------------------------------------------
// host port geometry
// ----------------------------------------------------------------------
`define EPM_ADDR_W 12
`define EPM_DATA_W 8

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define EPM_OFF_CHECKSUM 12'h90c
`define EPM_OFF_PAT_UPPER 12'h90d
`define EPM_OFF_PAT_LOWER 12'h90e
`define EPM_OFF_SLIP 12'h90f

// ----------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------
`define EPM_RST_CNT8 8'h00
`define EPM_RST_CNT16 16'h0000
`define EPM_MAX_CNT8 8'hff
`define EPM_MAX_CNT16 16'hffff
`define EPM_RD_IDLE 8'h00

`endif

//--- src/epm_pkg.sv
/*
 * Types shared by the error counter bank and its surroundings.
 * Assumes epm_defines.svh is on the include path.
 */
`default_nettype none
`include "epm_defines.svh"

package epm_pkg;

	// ------------------------------------------------------------------
	// host request and event carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [`EPM_ADDR_W-1:0] addr;
		logic wr;
		logic rd;
		logic [`EPM_DATA_W-1:0] wdata;
	} epm_req_t;

	typedef struct packed {
		logic checksum_err;
		logic pattern_err;
		logic slip_repeat;
		logic slip_drop;
	} epm_evt_t;

endpackage : epm_pkg

`default_nettype wire

//--- src/epm_counters.sv
/*
 * Performance-monitor error counter bank for one E1 channel: link
 * controller 1 checksum errors, receive pattern bit errors (16 bit) and
 * transmit frame slips, all cleared by reading.
 * Assumes event pulses come from logic on clk, one cycle per event, and a
 * host that reads the upper pattern byte before the lower one.
 */
`timescale 1ns/1ns
`default_nettype none
`include "epm_defines.svh"

// Notes on behaviour
// - 8-bit counter of checksum errors from link controller 1
// - each read returns count since last read and clears it
// - 16-bit pattern bit error counter split over two byte registers
// - upper register shows pattern count bits 15..8
// - lower register shows pattern count bits 7..0
// - upper then lower read takes away the 16-bit count seen at the upper read
// - 8-bit counter of transmit slip events
// - a slip is one frame repeated or one frame dropped
module epm_counters (
	input wire logic clk,
	input wire logic rst,
	input wire epm_pkg::epm_req_t host_req,
	input wire epm_pkg::epm_evt_t events,
	output logic [`EPM_DATA_W-1:0] rd_data
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [7:0] sat_add8(
		input logic [7:0] v,
		input logic [1:0] n
	);
		logic [8:0] s;
		s = {1'b0, v} + {7'h00, n};
		return s[8] ? `EPM_MAX_CNT8 : s[7:0];
	endfunction : sat_add8

	function automatic logic [15:0] sat_add16(
		input logic [15:0] v,
		input logic n
	);
		logic [16:0] s;
		s = {1'b0, v} + {16'h0000, n};
		return s[16] ? `EPM_MAX_CNT16 : s[15:0];
	endfunction : sat_add16

	// ------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------
	logic rd_checksum;
	logic rd_upper;
	logic rd_lower;
	logic rd_slip;
	logic [1:0] slip_n;

	assign rd_checksum = host_req.rd
		&& (host_req.addr == `EPM_OFF_CHECKSUM);
	assign rd_upper = host_req.rd && (host_req.addr == `EPM_OFF_PAT_UPPER);
	assign rd_lower = host_req.rd && (host_req.addr == `EPM_OFF_PAT_LOWER);
	assign rd_slip = host_req.rd && (host_req.addr == `EPM_OFF_SLIP);
	// repeat and drop are separate slips, both may land in one cycle
	assign slip_n = {1'b0, events.slip_repeat}
		+ {1'b0, events.slip_drop};

	// ------------------------------------------------------------------
	// counters
	// ------------------------------------------------------------------
	logic [7:0] checksum_err_count_bits;
	logic [15:0] pattern_err_count_bits;
	logic [15:0] pattern_snap;
	logic pattern_armed;
	logic [7:0] tx_slip_count_bits;

	// counters saturate rather than wrap so a slow poller sees overflow
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			checksum_err_count_bits <= `EPM_RST_CNT8;
		end else if (rd_checksum) begin
			checksum_err_count_bits <= {7'h00,
				events.checksum_err};
		end else begin
			checksum_err_count_bits <= sat_add8(checksum_err_count_bits,
				{1'b0, events.checksum_err});
		end
	end

	// lower read takes away only what the upper read reported, so
	// errors arriving between the two reads survive
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pattern_err_count_bits <= `EPM_RST_CNT16;
		end else if (rd_lower && pattern_armed) begin
			pattern_err_count_bits <= sat_add16(
				pattern_err_count_bits - pattern_snap,
				events.pattern_err);
		end else begin
			pattern_err_count_bits <= sat_add16(pattern_err_count_bits,
				events.pattern_err);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pattern_snap <= `EPM_RST_CNT16;
			pattern_armed <= 1'b0;
		end else if (rd_upper) begin
			pattern_snap <= pattern_err_count_bits;
			pattern_armed <= 1'b1;
		end else if (rd_lower) begin
			pattern_armed <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_slip_count_bits <= `EPM_RST_CNT8;
		end else if (rd_slip) begin
			tx_slip_count_bits <= {6'h00, slip_n};
		end else begin
			tx_slip_count_bits <= sat_add8(tx_slip_count_bits,
				slip_n);
		end
	end

	// ------------------------------------------------------------------
	// read data
	// ------------------------------------------------------------------
	logic [7:0] next_rd_data;

	// writes are accepted and ignored; unmapped reads return zero
	always_comb begin
		next_rd_data = `EPM_RD_IDLE;
		if (rd_checksum) begin
			next_rd_data = checksum_err_count_bits;
		end else if (rd_upper) begin
			next_rd_data = pattern_err_count_bits[15:8];
		end else if (rd_lower) begin
			// without a preceding upper read the live byte is shown
			next_rd_data = pattern_armed ? pattern_snap[7:0]
				: pattern_err_count_bits[7:0];
		end else if (rd_slip) begin
			next_rd_data = tx_slip_count_bits;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data <= `EPM_RD_IDLE;
		end else begin
			rd_data <= next_rd_data;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_checksum_inc;
		events.checksum_err && !rd_checksum
			&& checksum_err_count_bits != `EPM_MAX_CNT8
		|=> checksum_err_count_bits == $past(checksum_err_count_bits)
			+ 8'h01;
	endproperty
	a_checksum_inc: assert property (p_checksum_inc)
		else $error("checksum counter missed an error");

	property p_checksum_clear;
		rd_checksum |=> rd_data == $past(checksum_err_count_bits)
			&& checksum_err_count_bits
				== {7'h00, $past(events.checksum_err)};
	endproperty
	a_checksum_clear: assert property (p_checksum_clear)
		else $error("checksum read did not return and clear count");

	property p_upper_byte;
		rd_upper |=> rd_data == $past(pattern_err_count_bits[15:8]);
	endproperty
	a_upper_byte: assert property (p_upper_byte)
		else $error("upper pattern byte wrong");

	property p_lower_snapshot;
		rd_lower && pattern_armed
		|=> rd_data == $past(pattern_snap[7:0]);
	endproperty
	a_lower_snapshot: assert property (p_lower_snapshot)
		else $error("lower byte does not match upper-read snapshot");

	property p_lower_plain;
		rd_lower && !pattern_armed
		|=> rd_data == $past(pattern_err_count_bits[7:0]);
	endproperty
	a_lower_plain: assert property (p_lower_plain)
		else $error("unpaired lower read wrong");

	property p_pair_clear;
		rd_lower && pattern_armed && !events.pattern_err
		|=> pattern_err_count_bits == $past(pattern_err_count_bits)
			- $past(pattern_snap);
	endproperty
	a_pair_clear: assert property (p_pair_clear)
		else $error("ordered pair did not clear pattern count");

	property p_pattern_keep;
		rd_lower && pattern_armed && events.pattern_err
		|=> pattern_err_count_bits == $past(pattern_err_count_bits)
			- $past(pattern_snap) + 16'h0001;
	endproperty
	a_pattern_keep: assert property (p_pattern_keep)
		else $error("pattern error lost during clearing read");

	property p_slip_count;
		!rd_slip && tx_slip_count_bits < 8'hfe
		|=> tx_slip_count_bits == $past(tx_slip_count_bits)
			+ {6'h00, $past(slip_n)};
	endproperty
	a_slip_count: assert property (p_slip_count)
		else $error("slip counter wrong");

	property p_slip_either;
		events.slip_drop && !events.slip_repeat && !rd_slip
			&& tx_slip_count_bits != `EPM_MAX_CNT8
		|=> tx_slip_count_bits != $past(tx_slip_count_bits);
	endproperty
	a_slip_either: assert property (p_slip_either)
		else $error("dropped frame not counted as slip");

	property p_idle_zero;
		!host_req.rd |=> rd_data == `EPM_RD_IDLE;
	endproperty
	a_idle_zero: assert property (p_idle_zero)
		else $error("read data not zero outside read reply");

	// ------------------------------------------------------------------
	// pairing, saturation and write checks
	// ------------------------------------------------------------------
	property p_upper_arms;
		rd_upper |=> pattern_armed
			&& pattern_snap == $past(pattern_err_count_bits);
	endproperty
	a_upper_arms: assert property (p_upper_arms)
		else $error("upper read did not snapshot and arm");

	property p_lower_disarms;
		rd_lower |=> !pattern_armed;
	endproperty
	a_lower_disarms: assert property (p_lower_disarms)
		else $error("lower read left pair armed");

	// an unpaired lower read must not clear, only count on
	property p_lower_no_clear;
		rd_lower && !pattern_armed
			&& pattern_err_count_bits != `EPM_MAX_CNT16
		|=> pattern_err_count_bits == $past(pattern_err_count_bits)
			+ {15'h0000, $past(events.pattern_err)};
	endproperty
	a_lower_no_clear: assert property (p_lower_no_clear)
		else $error("unpaired lower read changed the count");

	property p_pattern_inc;
		events.pattern_err && !(rd_lower && pattern_armed)
			&& pattern_err_count_bits != `EPM_MAX_CNT16
		|=> pattern_err_count_bits == $past(pattern_err_count_bits)
			+ 16'h0001;
	endproperty
	a_pattern_inc: assert property (p_pattern_inc)
		else $error("pattern counter missed an error");

	// a poller must see 0xff stay, not wrap back to small counts
	property p_checksum_sat;
		checksum_err_count_bits == `EPM_MAX_CNT8 && !rd_checksum
		|=> checksum_err_count_bits == `EPM_MAX_CNT8;
	endproperty
	a_checksum_sat: assert property (p_checksum_sat)
		else $error("checksum counter wrapped");

	// every register is read-only, so a write may move nothing
	property p_write_ignored;
		host_req.wr && !host_req.rd && !events.checksum_err
		|=> checksum_err_count_bits == $past(checksum_err_count_bits);
	endproperty
	a_write_ignored: assert property (p_write_ignored)
		else $error("write changed the checksum counter");

	property p_slip_clear;
		rd_slip |=> rd_data == $past(tx_slip_count_bits)
			&& tx_slip_count_bits == {6'h00, $past(slip_n)};
	endproperty
	a_slip_clear: assert property (p_slip_clear)
		else $error("slip read did not return and clear count");

	c_pair: cover property (rd_upper ##[1:4] rd_lower);
	c_read_with_event: cover property (rd_checksum
		&& events.checksum_err);
	c_both_slips: cover property (events.slip_repeat
		&& events.slip_drop);
	c_pattern_mid: cover property (rd_upper ##1 events.pattern_err
		##1 rd_lower);
	c_slip_clear_event: cover property (rd_slip
		&& (events.slip_repeat || events.slip_drop));

endmodule : epm_counters

`default_nettype wire

//--- verification/tb_epm_counters.sv
/*
 * Self-checking bench for the error counter bank: host reads and writes,
 * event pulses, clear-on-read and the upper-then-lower pattern pair.
 * Assumes epm_pkg is compiled first and epm_defines.svh is on the path.
 */
`timescale 1ns/1ns
`default_nettype none
`include "epm_defines.svh"

module tb_epm_counters;
	localparam epm_pkg::epm_evt_t e_no = 4'h0;
	localparam epm_pkg::epm_evt_t e_ck = 4'h8;
	localparam epm_pkg::epm_evt_t e_pt = 4'h4;
	localparam epm_pkg::epm_evt_t e_sr = 4'h2;
	localparam epm_pkg::epm_evt_t e_sd = 4'h1;
	logic clk;
	logic rst;
	epm_pkg::epm_req_t req;
	epm_pkg::epm_evt_t ev;
	logic [`EPM_DATA_W-1:0] rd_data;
	int bad_count;
	int comparisons;

	epm_counters i_dut (
		.clk(clk),
		.rst(rst),
		.host_req(req),
		.events(ev),
		.rd_data(rd_data)
	);

	// ------------------------------------------------------------------
	// clock, closing and watchdog
	// ------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task print_verdict;
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict

	// whole run is about 650 cycles; allow ample margin
	initial begin
		#1000000;
		bad_count++;
		print_verdict();
	end

	// ------------------------------------------------------------------
	// host and event drivers
	// ------------------------------------------------------------------
	// event x rides along with the strobe, to hit the clearing cycle
	task automatic rd(input logic [11:0] a, input logic [7:0] e,
		input epm_pkg::epm_evt_t x);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'b1;
		ev <= x;
		@(posedge clk);
		req.rd <= 1'b0;
		ev <= e_no;
		@(negedge clk);
		comparisons++;
		if (rd_data !== e) begin
			$display("FAIL rd_data at %h expected %h seen %h", a, e, rd_data);
			bad_count++;
		end
	endtask : rd

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask : wr

	task automatic pulse(input epm_pkg::epm_evt_t x, input int n);
		repeat (n) begin
			@(posedge clk);
			ev <= x;
		end
		@(posedge clk);
		ev <= e_no;
	endtask : pulse

	// ------------------------------------------------------------------
	// tests
	// ------------------------------------------------------------------
	initial begin
		bad_count = 0;
		comparisons = 0;
		req = '0;
		ev = e_no;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(`EPM_OFF_CHECKSUM, 8'h00, e_no);
		rd(`EPM_OFF_PAT_UPPER, 8'h00, e_no);
		rd(`EPM_OFF_PAT_LOWER, 8'h00, e_no);
		rd(`EPM_OFF_SLIP, 8'h00, e_no);
		pulse(e_ck, 5);
		rd(`EPM_OFF_CHECKSUM, 8'h05, e_no);
		rd(`EPM_OFF_CHECKSUM, 8'h00, e_no);
		// writes have no effect, unmapped reads give idle data
		pulse(e_ck, 2);
		wr(`EPM_OFF_CHECKSUM, 8'h55);
		rd(12'h910, `EPM_RD_IDLE, e_no);
		rd(`EPM_OFF_CHECKSUM, 8'h02, e_ck);
		rd(`EPM_OFF_CHECKSUM, 8'h01, e_no);
		pulse(e_ck, 260);
		rd(`EPM_OFF_CHECKSUM, `EPM_MAX_CNT8, e_no);
		// frame repeats and drops both count, together as two
		pulse(e_sr, 3);
		pulse(e_sd, 2);
		pulse(e_sr | e_sd, 2);
		rd(`EPM_OFF_SLIP, 8'h09, e_sr | e_sd);
		rd(`EPM_OFF_SLIP, 8'h02, e_no);
		rd(`EPM_OFF_SLIP, 8'h00, e_no);
		// 300 = 16'h012c; later events must survive the pair clear
		pulse(e_pt, 300);
		rd(`EPM_OFF_PAT_UPPER, 8'h01, e_pt);
		pulse(e_pt, 2);
		rd(`EPM_OFF_CHECKSUM, 8'h00, e_no);
		rd(`EPM_OFF_PAT_LOWER, 8'h2c, e_no);
		rd(`EPM_OFF_PAT_UPPER, 8'h00, e_no);
		rd(`EPM_OFF_PAT_LOWER, 8'h03, e_pt);
		rd(`EPM_OFF_PAT_UPPER, 8'h00, e_no);
		rd(`EPM_OFF_PAT_LOWER, 8'h01, e_no);
		rd(`EPM_OFF_PAT_UPPER, 8'h00, e_no);
		rd(`EPM_OFF_PAT_LOWER, 8'h00, e_no);
		// lower alone shows live byte and clears nothing
		pulse(e_pt, 2);
		rd(`EPM_OFF_PAT_LOWER, 8'h02, e_no);
		rd(`EPM_OFF_PAT_LOWER, 8'h02, e_no);
		rd(`EPM_OFF_PAT_UPPER, 8'h00, e_no);
		rd(`EPM_OFF_PAT_LOWER, 8'h02, e_no);
		rd(`EPM_OFF_PAT_LOWER, 8'h00, e_no);
		print_verdict();
	end
endmodule : tb_epm_counters

`default_nettype wire
